// ===== rtl/stsu_top.v
// Purpose: Software trace stimulus unit with delta timestamps.
// Assumes: One clock at 50 MHz; line-out clock and idle come from another
//          domain and are synchronised here.
// Notes:   Register port completes every access in one cycle, never errs.
`timescale 1ns/1ns
`default_nettype none
`include "stsu_consts.vh"

module stsu_top (
    input  wire        clock,
    input  wire        rst,
    input  wire        bus_valid,
    input  wire        bus_write,
    input  wire        bus_priv,
    input  wire [1:0]  bus_size,
    input  wire [11:0] bus_addr,
    input  wire [31:0] bus_wdata,
    output wire [31:0] bus_rdata,
    output wire        bus_rvalid,
    input  wire        wp_valid,
    output wire        wp_ready,
    input  wire [31:0] wp_data,
    input  wire        dbg_halt,
    input  wire        lineout_clk,
    input  wire        port_idle,
    output wire        pkt_valid,
    input  wire        pkt_ready,
    output wire [1:0]  pkt_kind,
    output wire [7:0]  pkt_port,
    output wire [1:0]  pkt_size,
    output wire [31:0] pkt_data,
    output wire [1:0]  pkt_flags
);
    reg  [31:0]              ter_ff;
    reg  [3:0]               tpr_ff;
    reg                      gen_ff;
    reg                      tsen_ff;
    reg                      csel_ff;
    reg  [1:0]               pre_ff;
    reg  [31:0]              rdata_ff;
    reg                      rvalid_ff;
    reg                      wp_full_ff;
    reg  [31:0]              wp_buf_ff;
    reg                      ovf_pend_ff;
    reg                      ts_pend_ff;
    reg                      ts_late_ff;
    reg                      ev_late_ff;
    reg  [`STSU_TS_W-1:0]    cnt_ff;
    reg  [5:0]               div_ff;
    reg                      lo_s1_ff;
    reg                      lo_s2_ff;
    reg                      lo_s3_ff;
    reg                      idle_s1_ff;
    reg                      idle_s2_ff;
    reg                      out_valid_ff;
    reg  [1:0]               out_kind_ff;
    reg  [7:0]               out_port_ff;
    reg  [1:0]               out_size_ff;
    reg  [31:0]              out_data_ff;
    reg  [1:0]               out_flags_ff;
    reg  [31:0]              nxt_rdata;
    reg  [`STSU_TS_W-1:0]    nxt_cnt;
    reg  [5:0]               nxt_div;
    wire                     wr;
    wire                     in_stim;
    wire [4:0]               port;
    wire                     stim_ok;
    wire                     fifo_in_ready;
    wire                     fifo_push;
    wire                     fifo_out_valid;
    wire [`STSU_FIFO_W-1:0]  fifo_out_data;
    wire                     fifo_empty;
    wire [31:0]              wmask;
    wire                     wp_take;
    wire                     load;
    wire                     sel_ovf;
    wire                     sel_stim;
    wire                     sel_wp;
    wire                     sel_ts;
    wire                     ovf_set;
    wire                     ts_run;
    wire                     ts_hold;
    wire                     ts_tick;
    wire                     ts_wrap;
    wire                     ev;
    wire                     ts_ev;
    wire [5:0]               div_last;

    // Lanes of an aligned stimulus write that carry data.
    function [31:0] size_mask;
        input [1:0] size;
        begin
            case (size)
                `STSU_SZ_BYTE: size_mask = 32'h0000_00ff;
                `STSU_SZ_HALF: size_mask = 32'h0000_ffff;
                default:       size_mask = 32'hffff_ffff;
            endcase
        end
    endfunction

    // Port enable bits that the current access may write.
    function [31:0] group_mask;
        input [3:0] tpr;
        input       priv;
        integer     g;
        begin
            group_mask = 32'h0000_0000;
            for (g = 0; g < `STSU_NUM_GROUPS; g = g + 1) begin
                group_mask[g*8 +: 8] = {8{priv | tpr[g]}};
            end
        end
    endfunction

    // Smallest byte count holding the delta value, coded count minus one.
    function [1:0] ts_len;
        input [`STSU_TS_W-1:0] c;
        begin
            if (c[27:21] != 7'h00) begin
                ts_len = 2'h3;
            end else if (c[20:14] != 7'h00) begin
                ts_len = 2'h2;
            end else if (c[13:7] != 7'h00) begin
                ts_len = 2'h1;
            end else begin
                ts_len = 2'h0;
            end
        end
    endfunction

    assign wr      = bus_valid && bus_write;
    assign in_stim = (bus_addr[11:7] == 5'h00);
    assign port    = bus_addr[6:2];
    assign wmask   = group_mask(tpr_ff, bus_priv);
    assign stim_ok = wr && in_stim && gen_ff && ter_ff[port] &&
                     wmask[port];
    assign fifo_push = stim_ok && fifo_in_ready;
    assign ovf_set   = (stim_ok && !fifo_in_ready) || ts_wrap;

    stsu_fifo #(
        .WIDTH (`STSU_FIFO_W),
        .DEPTH (`STSU_FIFO_D),
        .AW    (`STSU_FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   ({bus_size, 3'h0, port,
                     bus_wdata & size_mask(bus_size)}),
        .out_valid (fifo_out_valid),
        .out_ready (load && sel_stim),
        .out_data  (fifo_out_data),
        .empty     (fifo_empty)
    );

    // Registers; privileged writes need the enable, except the control word.
    always @(posedge clock) begin
        if (rst) begin
            ter_ff  <= `STSU_RST_TER;
            tpr_ff  <= `STSU_RST_TPR;
            gen_ff  <= 1'b0;
            tsen_ff <= 1'b0;
            csel_ff <= 1'b0;
            pre_ff  <= `STSU_RST_PRE;
        end else if (wr) begin
            if (bus_addr == `STSU_OFF_TER && gen_ff) begin
                ter_ff <= (ter_ff & ~wmask) | (bus_wdata & wmask);
            end
            if (bus_addr == `STSU_OFF_TPR && bus_priv &&
                gen_ff) begin
                tpr_ff <= bus_wdata[3:0];
            end
            if (bus_addr == `STSU_OFF_TCR && bus_priv) begin
                gen_ff  <= bus_wdata[`STSU_TCR_GEN_BIT];
                tsen_ff <= bus_wdata[`STSU_TCR_TSEN_BIT];
                csel_ff <= bus_wdata[`STSU_TCR_CSEL_BIT];
                pre_ff  <= bus_wdata[`STSU_TCR_PRE_HI:`STSU_TCR_PRE_LO];
            end
        end
    end

    // Reads are open to every access and never fault.
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (in_stim) begin
            nxt_rdata[0] = gen_ff && ter_ff[port] &&
                           fifo_in_ready;
        end else if (bus_addr == `STSU_OFF_TER) begin
            nxt_rdata = ter_ff;
        end else if (bus_addr == `STSU_OFF_TPR) begin
            nxt_rdata[3:0] = tpr_ff;
        end else if (bus_addr == `STSU_OFF_TCR) begin
            nxt_rdata[`STSU_TCR_GEN_BIT]  = gen_ff;
            nxt_rdata[`STSU_TCR_TSEN_BIT] = tsen_ff;
            nxt_rdata[`STSU_TCR_CSEL_BIT] = csel_ff;
            nxt_rdata[`STSU_TCR_PRE_HI:`STSU_TCR_PRE_LO] = pre_ff;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= bus_valid && !bus_write;
            if (bus_valid && !bus_write) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign bus_rdata  = rdata_ff;
    assign bus_rvalid = rvalid_ff;

    // Watchpoint traffic has its own one-entry buffer.
    assign wp_ready = !wp_full_ff;
    assign wp_take  = wp_valid && !wp_full_ff;

    always @(posedge clock) begin
        if (rst) begin
            wp_full_ff <= 1'b0;
            wp_buf_ff  <= 32'h0000_0000;
        end else if (wp_take) begin
            wp_full_ff <= 1'b1;
            wp_buf_ff  <= wp_data;
        end else if (load && sel_wp) begin
            wp_full_ff <= 1'b0;
        end
    end

    // Line-out clock and idle level cross into this domain.
    always @(posedge clock) begin
        if (rst) begin
            lo_s1_ff   <= 1'b0;
            lo_s2_ff   <= 1'b0;
            lo_s3_ff   <= 1'b0;
            idle_s1_ff <= 1'b1;
            idle_s2_ff <= 1'b1;
        end else begin
            lo_s1_ff   <= lineout_clk;
            lo_s2_ff   <= lo_s1_ff;
            lo_s3_ff   <= lo_s2_ff;
            idle_s1_ff <= port_idle;
            idle_s2_ff <= idle_s1_ff;
        end
    end

    // Divider last count for ratios of 1, 4, 16 and 64.
    assign div_last = (pre_ff == 2'h0) ? 6'h00 :
                      (pre_ff == 2'h1) ? 6'h03 :
                      (pre_ff == 2'h2) ? 6'h0f : 6'h3f;
    assign ts_run  = gen_ff && tsen_ff;
    assign ts_hold = csel_ff && idle_s2_ff;
    assign ts_tick = ts_run && (csel_ff ?
                     (lo_s2_ff && !lo_s3_ff && div_ff == div_last) :
                     !dbg_halt);
    assign ts_wrap = ts_tick && (cnt_ff == {`STSU_TS_W{1'b1}});
    assign ev      = fifo_push || wp_take;
    assign ts_ev   = ts_run && ev && (cnt_ff != {`STSU_TS_W{1'b0}});

    always @* begin
        nxt_div = div_ff;
        if (ts_hold || !csel_ff) begin
            nxt_div = 6'h00;
        end else if (ts_run && lo_s2_ff && !lo_s3_ff) begin
            nxt_div = (div_ff == div_last) ? 6'h00 : div_ff + 6'h01;
        end
        nxt_cnt = cnt_ff;
        if (ts_hold) begin
            nxt_cnt = {`STSU_TS_W{1'b0}};
        end else if (load && sel_ts) begin
            nxt_cnt = {`STSU_TS_W{1'b0}};
        end else if (ts_tick) begin
            nxt_cnt = cnt_ff + {{(`STSU_TS_W-1){1'b0}}, 1'b1};
        end
    end

    // Pending flags: a new event wins over the clear in the same cycle.
    always @(posedge clock) begin
        if (rst) begin
            cnt_ff      <= {`STSU_TS_W{1'b0}};
            div_ff      <= 6'h00;
            ovf_pend_ff <= 1'b0;
            ts_pend_ff  <= 1'b0;
            ts_late_ff  <= 1'b0;
            ev_late_ff  <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            div_ff      <= nxt_div;
            ovf_pend_ff <= (ovf_pend_ff && !(load && sel_ovf)) || ovf_set;
            ts_pend_ff  <= (ts_pend_ff && !(load && sel_ts)) ||
                           ts_ev || ts_wrap;
            if (ts_ev || ts_wrap) begin
                ev_late_ff <= !fifo_empty || wp_full_ff ||
                              out_valid_ff;
                ts_late_ff <= 1'b0;
            end else if (ts_pend_ff && load && !sel_ts &&
                         (sel_ovf || sel_stim || sel_wp)) begin
                ts_late_ff <= 1'b1;
            end
        end
    end

    // Output arbitration, overflow and stimulus before watchpoint, then time.
    assign load     = !out_valid_ff || pkt_ready;
    assign sel_ovf  = ovf_pend_ff;
    assign sel_stim = !ovf_pend_ff && fifo_out_valid;
    assign sel_wp   = !ovf_pend_ff && !fifo_out_valid && wp_full_ff;
    assign sel_ts   = !ovf_pend_ff && !fifo_out_valid && !wp_full_ff &&
                      ts_pend_ff;

    always @(posedge clock) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
            out_kind_ff  <= `STSU_PK_STIM;
            out_port_ff  <= 8'h00;
            out_size_ff  <= 2'h0;
            out_data_ff  <= 32'h0000_0000;
            out_flags_ff <= 2'h0;
        end else if (load) begin
            out_valid_ff <= sel_ovf || sel_stim || sel_wp || sel_ts;
            out_flags_ff <= 2'h0;
            if (sel_ovf) begin
                out_kind_ff <= `STSU_PK_OVF;
                out_port_ff <= 8'h00;
                out_size_ff <= 2'h0;
                out_data_ff <= 32'h0000_0000;
            end else if (sel_stim) begin
                out_kind_ff <= `STSU_PK_STIM;
                out_size_ff <= fifo_out_data[41:40];
                out_port_ff <= fifo_out_data[39:32];
                out_data_ff <= fifo_out_data[31:0];
            end else if (sel_wp) begin
                out_kind_ff <= `STSU_PK_WP;
                out_port_ff <= 8'h00;
                out_size_ff <= `STSU_SZ_WORD;
                out_data_ff <= wp_buf_ff;
            end else if (sel_ts) begin
                out_kind_ff  <= `STSU_PK_TS;
                out_port_ff  <= 8'h00;
                out_size_ff  <= ts_len(cnt_ff);
                out_data_ff  <= {4'h0, cnt_ff};
                out_flags_ff <= {ts_late_ff, ev_late_ff};
            end
        end
    end

    assign pkt_valid = out_valid_ff;
    assign pkt_kind  = out_kind_ff;
    assign pkt_port  = out_port_ff;
    assign pkt_size  = out_size_ff;
    assign pkt_data  = out_data_ff;
    assign pkt_flags = out_flags_ff;
endmodule
`default_nettype wire

// ===== rtl/stsu_consts.vh
// Purpose: Constants for the software trace stimulus unit.
// Assumes: Byte addresses within the unit's own 4 KB register window.
// Notes:   Offsets, field positions, reset values and packet codes.
`ifndef STSU_CONSTS_VH
`define STSU_CONSTS_VH

// Implemented stimulus ports and their groups of eight.
`define STSU_NUM_PORTS      32
`define STSU_NUM_GROUPS     4

// Register byte offsets.
`define STSU_OFF_TER        12'he00
`define STSU_OFF_TPR        12'he40
`define STSU_OFF_TCR        12'he80

// Trace control register field positions.
`define STSU_TCR_GEN_BIT    0
`define STSU_TCR_TSEN_BIT   1
`define STSU_TCR_CSEL_BIT   4
`define STSU_TCR_PRE_LO     8
`define STSU_TCR_PRE_HI     9

// Reset values.
`define STSU_RST_TER        32'h0000_0000
`define STSU_RST_TPR        4'h0
`define STSU_RST_PRE        2'h0

// Access size codes on the register port.
`define STSU_SZ_BYTE        2'h0
`define STSU_SZ_HALF        2'h1
`define STSU_SZ_WORD        2'h2

// Packet kinds on the trace stream.
`define STSU_PK_STIM        2'h0
`define STSU_PK_WP          2'h1
`define STSU_PK_OVF         2'h2
`define STSU_PK_TS          2'h3

// Delta counter width and output buffer shape.
`define STSU_TS_W           28
`define STSU_FIFO_W         42
`define STSU_FIFO_D         8
`define STSU_FIFO_AW        3

`endif

// ===== rtl/stsu_fifo.v
// Purpose: Shared stimulus output buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active high reset.
// Notes:   Depth must be a power of two matching the address width.
`timescale 1ns/1ns
`default_nettype none
module stsu_fifo #(
    parameter WIDTH = 42,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clock,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             empty
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;
    wire            full;
    wire            push;
    wire            pop;

    assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                       (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty     = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

    // Storage words carry no reset; only the pointers define emptiness.
    always @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/stsu_properties.sv
// Purpose: Concurrent checks on the ports of the trace stimulus unit.
// Assumes: One clock domain, synchronous active high reset.
// Notes:   A shadow of the global enable follows privileged control writes.
`timescale 1ns/1ns
`default_nettype none
`include "stsu_consts.vh"
module stsu_props (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        bus_valid,
    input wire logic        bus_write,
    input wire logic        bus_priv,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic        bus_rvalid,
    input wire logic        wp_valid,
    input wire logic        wp_ready,
    input wire logic        pkt_valid,
    input wire logic        pkt_ready,
    input wire logic [1:0]  pkt_kind,
    input wire logic [7:0]  pkt_port,
    input wire logic [1:0]  pkt_size,
    input wire logic [31:0] pkt_data,
    input wire logic [1:0]  pkt_flags
);
    logic en_ff;
    logic rd_req;
    assign rd_req = bus_valid && !bus_write;
    // Shadow of the global enable.
    always @(posedge clock) begin
        if (rst) begin
            en_ff <= 1'b0;
        end else if (bus_valid && bus_write && bus_priv
                     && bus_addr == `STSU_OFF_TCR) begin
            en_ff <= bus_wdata[0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_read_answered: assert property (rd_req |=> bus_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (bus_rvalid |-> $past(rd_req))
        else $error("read answer without request");
    a_stall_hold: assert property (pkt_valid && !pkt_ready |=> pkt_valid
        && $stable({pkt_kind, pkt_port, pkt_size, pkt_data, pkt_flags}))
        else $error("packet changed while stalled");
    a_status_bits: assert property (rd_req && bus_addr < 12'h400
        |=> bus_rdata[31:1] == 31'h0) else $error("port read upper bits");
    a_disabled_full: assert property (rd_req && bus_addr < 12'h080 && !en_ff
        |=> bus_rdata[0] == 1'b0) else $error("disabled port not full");
    a_mask_width: assert property (rd_req && bus_addr == `STSU_OFF_TPR
        |=> bus_rdata[31:4] == 28'h0) else $error("mask reads extra bits");
    a_ovf_fields: assert property (pkt_valid && pkt_kind == `STSU_PK_OVF
        |-> {pkt_port, pkt_size, pkt_data, pkt_flags} == 44'h0)
        else $error("overflow packet fields");
    a_size_mask: assert property (pkt_valid && pkt_kind == `STSU_PK_STIM
        |-> !(pkt_size == `STSU_SZ_BYTE && |pkt_data[31:8])
        && !(pkt_size == `STSU_SZ_HALF && |pkt_data[31:16]))
        else $error("stimulus data wider than size");
    a_ts_count: assert property (pkt_valid && pkt_kind == `STSU_PK_TS
        |-> pkt_data != 32'h0 && pkt_data[31:28] == 4'h0)
        else $error("timestamp count out of range");
    a_ts_smallest: assert property (pkt_valid && pkt_kind == `STSU_PK_TS
        |-> pkt_size == ((pkt_data < 32'h80) ? 2'h0 : (pkt_data < 32'h4000)
        ? 2'h1 : (pkt_data < 32'h20_0000) ? 2'h2 : 2'h3))
        else $error("timestamp not smallest form");
    a_wp_busy: assert property (wp_valid && wp_ready |=> !wp_ready)
        else $error("watchpoint buffer not busy");
    c_ovf: cover property (pkt_valid && pkt_kind == `STSU_PK_OVF);
    c_ts: cover property (pkt_valid && pkt_kind == `STSU_PK_TS);
    c_stall: cover property (pkt_valid && !pkt_ready ##1 pkt_ready);
    c_wp: cover property (wp_valid && wp_ready);
endmodule
`default_nettype wire

// ===== tb/stsu_sink.sv
// Purpose: Model of the trace port unit that takes the packet stream.
// Assumes: A packet is taken at a rising edge with valid and ready high.
// Notes:   Ready may stall or toggle; line-out clock runs only when busy.
`timescale 1ns/1ns
`default_nettype none
module stsu_sink (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic stall,
    input  wire logic slow,
    input  wire logic busy,
    output logic      pkt_ready,
    output logic      lineout_clk,
    output logic      port_idle
);
    // Ready changes on the falling edge.
    always @(negedge clock) begin
        pkt_ready <= !rst && !stall && (!slow || !pkt_ready);
    end
    // Line-out clock is still while idle.
    always #35 lineout_clk = busy ? !lineout_clk : 1'b0;
    assign port_idle = !busy;
endmodule
`default_nettype wire

// ===== tb/test_software_trace_stimulus_unit.sv
// Purpose: Self-checking bench for the software trace stimulus unit.
// Assumes: Sink model on the packet port; one clock at 50 MHz.
// Notes:   Expected reads and packets wait in queues for the monitor.
`timescale 1ns/1ns
`default_nettype none
`include "stsu_consts.vh"
module test_software_trace_stimulus_unit;
    localparam [43:0] ALL = {44{1'b1}};
    localparam [43:0] NODATA = {12'hffc, 32'h0};
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        bus_valid = 1'b0;
    logic        bus_write = 1'b0;
    logic        bus_priv = 1'b0;
    logic [1:0]  bus_size = 2'h0;
    logic [11:0] bus_addr = 12'h000;
    logic [31:0] bus_wdata = 32'h0;
    logic        wp_valid = 1'b0;
    logic [31:0] wp_data = 32'h0;
    logic        dbg_halt = 1'b0;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    logic        busy = 1'b0;
    wire  [31:0] bus_rdata;
    wire  [31:0] pkt_data;
    wire  [7:0]  pkt_port;
    wire  [1:0]  pkt_kind, pkt_size, pkt_flags;
    wire         bus_rvalid, wp_ready, lineout_clk, port_idle;
    wire         pkt_valid, pkt_ready;
    integer      errors = 0;
    integer      n_compared = 0;
    integer      seed = 32'h7c151585;
    logic [31:0] rq[$];
    logic [87:0] pq[$];
    logic [31:0] d[0:8];

    always #10 clock = ~clock;

    stsu_top DUT (.clock(clock), .rst(rst), .bus_valid(bus_valid),
        .bus_write(bus_write), .bus_priv(bus_priv), .bus_size(bus_size),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .wp_valid(wp_valid), .wp_ready(wp_ready),
        .wp_data(wp_data), .dbg_halt(dbg_halt), .lineout_clk(lineout_clk),
        .port_idle(port_idle), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
        .pkt_kind(pkt_kind), .pkt_port(pkt_port), .pkt_size(pkt_size),
        .pkt_data(pkt_data), .pkt_flags(pkt_flags));
    stsu_sink u_sink (.clock(clock), .rst(rst), .stall(stall), .slow(slow),
        .busy(busy), .pkt_ready(pkt_ready), .lineout_clk(lineout_clk),
        .port_idle(port_idle));

    task automatic summarize;
        errors = errors + rq.size() + pq.size();
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic acc(input logic wr, input logic pv, input logic [1:0] sz,
                       input logic [11:0] a, input logic [31:0] wd);
        @(negedge clock);
        {bus_valid, bus_write, bus_priv, bus_size} = {1'b1, wr, pv, sz};
        bus_addr = a;
        bus_wdata = wd;
        @(negedge clock);
        bus_valid = 1'b0;
    endtask
    task automatic wr(input logic pv, input logic [11:0] a,
                      input logic [31:0] v);
        acc(1'b1, pv, `STSU_SZ_WORD, a, v);
    endtask
    task automatic rd(input logic pv, input logic [11:0] a,
                      input logic [31:0] e);
        rq.push_back(e);
        acc(1'b0, pv, `STSU_SZ_WORD, a, 32'h0);
    endtask
    task automatic ep(input logic [1:0] k, input logic [7:0] p,
        input logic [1:0] s, input logic [31:0] v, input logic [43:0] m);
        pq.push_back({k, p, s, v, m});
    endtask
    task automatic sw(input logic pv, input logic [1:0] sz,
        input logic [7:0] p, input logic [31:0] v, input logic ex);
        logic [31:0] m;
        m = (sz == `STSU_SZ_BYTE) ? 32'hff
          : (sz == `STSU_SZ_HALF) ? 32'hffff : 32'hffff_ffff;
        if (ex) ep(`STSU_PK_STIM, p, sz, v & m, ALL);
        acc(1'b1, pv, sz, {p[5:0], 2'b00}, v);
    endtask
    task automatic chk_rd(input logic [31:0] got);
        logic [31:0] e;
        e = (rq.size() != 0) ? rq.pop_front() : ~got;
        n_compared++;
        if (got !== e) begin
            errors++;
            $display("ERROR t=%0t read exp=%h got=%h", $time, e, got);
        end
    endtask
    task automatic chk_pkt(input logic [43:0] got);
        logic [87:0] e;
        e = (pq.size() != 0) ? pq.pop_front() : {~got, ALL};
        n_compared++;
        if ((got & e[43:0]) !== (e[87:44] & e[43:0])) begin
            errors++;
            $display("ERROR t=%0t packet exp=%h got=%h", $time, e[87:44], got);
        end
    endtask
    task automatic drain(input string nm);
        int k;
        for (k = 0; k < 300 && pq.size() != 0; k++) @(posedge clock);
        repeat (8) @(negedge clock);
        $display("test %s done, errors=%0d", nm, errors);
    endtask

    always @(posedge clock) begin
        if (!rst && bus_rvalid) chk_rd(bus_rdata);
        if (!rst && pkt_valid && pkt_ready)
            chk_pkt({pkt_kind, pkt_port, pkt_size, pkt_data});
    end

    initial begin
        #200000;
        errors++;
        $display("ERROR t=%0t watchdog exp=%h got=%h", $time, 0, 1);
        summarize();
    end

    initial begin
        int i;
        logic [7:0] p;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        rd(1'b1, `STSU_OFF_TCR, 32'h0);
        rd(1'b0, 12'h004, 32'h0);
        sw(1'b1, `STSU_SZ_WORD, 8'h01, 32'h1, 1'b0);
        wr(1'b1, `STSU_OFF_TPR, 32'hffff_ffff);
        rd(1'b1, `STSU_OFF_TPR, 32'h0);
        wr(1'b1, `STSU_OFF_TCR, 32'h1);
        wr(1'b1, `STSU_OFF_TPR, 32'hffff_ffff);
        rd(1'b0, `STSU_OFF_TPR, 32'hf);
        wr(1'b1, `STSU_OFF_TER, 32'hffff_ffff);
        rd(1'b0, `STSU_OFF_TER, 32'hffff_ffff);
        wr(1'b0, `STSU_OFF_TCR, 32'h0);
        wr(1'b0, `STSU_OFF_TPR, 32'h0);
        rd(1'b1, `STSU_OFF_TCR, 32'h1);
        rd(1'b1, `STSU_OFF_TPR, 32'hf);
        drain("registers");
        slow = 1'b1;
        for (i = 0; i < 12; i++) begin
            p = {3'h0, 5'($random(seed))};
            sw(i[0], 2'(i % 3), p, $random(seed), 1'b1);
        end
        slow = 1'b0;
        drain("sizes");
        wr(1'b1, `STSU_OFF_TPR, 32'h1);
        sw(1'b0, `STSU_SZ_WORD, 8'd3, 32'h33, 1'b1);
        sw(1'b0, `STSU_SZ_WORD, 8'd9, 32'h99, 1'b0);
        sw(1'b1, `STSU_SZ_WORD, 8'd9, 32'h9a, 1'b1);
        wr(1'b1, `STSU_OFF_TER, 32'hffff_fffe);
        sw(1'b1, `STSU_SZ_WORD, 8'd0, 32'h5, 1'b0);
        rd(1'b0, 12'h000, 32'h0);
        rd(1'b0, 12'h004, 32'h1);
        rd(1'b1, 12'h100, 32'h0);
        wr(1'b1, `STSU_OFF_TER, 32'hffff_ffff);
        wr(1'b1, `STSU_OFF_TPR, 32'hf);
        drain("enables");
        stall = 1'b1;
        for (i = 0; i < 9; i++) d[i] = $random(seed);
        ep(`STSU_PK_STIM, 8'h0, `STSU_SZ_WORD, d[0], ALL);
        ep(`STSU_PK_OVF, 8'h0, 2'h0, 32'h0, ALL);
        for (i = 1; i < 9; i++)
            ep(`STSU_PK_STIM, 8'(i), `STSU_SZ_WORD, d[i], ALL);
        for (i = 0; i < 9; i++) sw(1'b1, `STSU_SZ_WORD, 8'(i), d[i], 1'b0);
        rd(1'b1, 12'h004, 32'h0);
        sw(1'b1, `STSU_SZ_WORD, 8'd20, 32'hbad, 1'b0);
        stall = 1'b0;
        drain("overflow");
        stall = 1'b1;
        ep(`STSU_PK_WP, 8'h0, `STSU_SZ_WORD, 32'hc0ffee01, ALL);
        @(negedge clock);
        wp_valid = 1'b1;
        wp_data = 32'hc0ffee01;
        @(negedge clock);
        wp_valid = 1'b0;
        rd(1'b1, 12'h008, 32'h1);
        stall = 1'b0;
        drain("watchpoint");
        dbg_halt = 1'b1;
        wr(1'b1, `STSU_OFF_TCR, 32'h3);
        repeat (5) @(negedge clock);
        sw(1'b1, `STSU_SZ_WORD, 8'd4, 32'h44, 1'b1);
        drain("halt");
        dbg_halt = 1'b0;
        repeat (20) @(negedge clock);
        sw(1'b1, `STSU_SZ_WORD, 8'd5, 32'h55, 1'b1);
        ep(`STSU_PK_TS, 8'h0, 2'h0, 32'h0, NODATA);
        drain("timestamp");
        wr(1'b1, `STSU_OFF_TCR, 32'h313);
        repeat (20) @(negedge clock);
        sw(1'b1, `STSU_SZ_WORD, 8'd6, 32'h66, 1'b1);
        busy = 1'b1;
        repeat (300) @(negedge clock);
        sw(1'b1, `STSU_SZ_WORD, 8'd7, 32'h77, 1'b1);
        ep(`STSU_PK_TS, 8'h0, 2'h0, 32'h0, NODATA);
        drain("line-out");
        summarize();
    end
endmodule
bind stsu_top stsu_props u_props (.clock(clock), .rst(rst),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_priv(bus_priv),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .wp_valid(wp_valid), .wp_ready(wp_ready),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_kind(pkt_kind),
    .pkt_port(pkt_port), .pkt_size(pkt_size), .pkt_data(pkt_data),
    .pkt_flags(pkt_flags));
`default_nettype wire
